// *** bench/addr_mode_checker_assertions.sv ***
`timescale 1ns/1ps
module addr_mode_checker
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	input wire logic spi_so,
	input wire logic spi_so_oe_n,
	input wire logic [7:0] nv_sr1_value,
	input wire logic nv_sr1_write,
	input wire logic [7:0] nv_sr1_data,
	input wire logic [31:0] cap_word,
	input wire logic [7:0] bank_value,
	input wire logic [7:0] sr1_value,
	input wire logic cmd_valid,
	input wire logic [7:0] cmd_opcode,
	input wire logic [31:0] cmd_addr,
	input wire logic cmd_4byte
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	cap_word_a: assert property (cap_word == 32'h0000_0243)
		else $error("capability word wrong");
	bank_reset_a: assert property ($rose(rst_n) |-> bank_value == 8'h00)
		else $error("bank not cleared");
	sr1_load_a: assert property ($rose(rst_n) |=> sr1_value == $past(nv_sr1_value))
		else $error("status not loaded");
	segment_addr_a: assert property (cmd_valid && !cmd_4byte
		|-> cmd_addr[31:24] == {1'b0, bank_value[6:0]}) else $error("segment bits wrong");
	mode_select_a: assert property (cmd_valid && cmd_opcode inside
		{8'h03, 8'h0B, 8'h02, 8'h20} |-> cmd_4byte == bank_value[7]) else $error("mode wrong");
	dedicated_wide_a: assert property (cmd_valid && cmd_opcode inside
		{8'h13, 8'h0C, 8'h12, 8'h21} |-> cmd_4byte) else $error("wide opcode narrow");
	read_drive_a: assert property ($fell(spi_so_oe_n) |-> !spi_cs_n)
		else $error("drive outside frame");
	nv_pulse_a: assert property (nv_sr1_write |-> nv_sr1_data == sr1_value ##1 !nv_sr1_write)
		else $error("nonvolatile write wrong");
endmodule
bind addr_mode_ctrl addr_mode_checker u_chk (
	.clk(clk),
	.rst_n(rst_n),
	.spi_sck(spi_sck),
	.spi_cs_n(spi_cs_n),
	.spi_si(spi_si),
	.spi_so(spi_so),
	.spi_so_oe_n(spi_so_oe_n),
	.nv_sr1_value(nv_sr1_value),
	.nv_sr1_write(nv_sr1_write),
	.nv_sr1_data(nv_sr1_data),
	.cap_word(cap_word),
	.bank_value(bank_value),
	.sr1_value(sr1_value),
	.cmd_valid(cmd_valid),
	.cmd_opcode(cmd_opcode),
	.cmd_addr(cmd_addr),
	.cmd_4byte(cmd_4byte)
);

// *** bench/flash_address_mode_bank_control_bench.sv ***
`timescale 1ns/1ps
module flash_address_mode_bank_control_bench;
	logic clk, rst_n, spi_sck, spi_cs_n, spi_si, spi_so, spi_so_oe_n;
	logic nv_sr1_write, cmd_valid, cmd_4byte;
	logic [7:0] nv_sr1_value, nv_sr1_data, bank_value, sr1_value, cmd_opcode, rx;
	logic [31:0] cap_word, cmd_addr;
	logic [7:0] ops3[4] = '{8'h03, 8'h0B, 8'h02, 8'h20};
	logic [7:0] ops4[4] = '{8'h13, 8'h0C, 8'h12, 8'h21};
	logic [40:0] exp_q[$];
	logic [40:0] cmd_seen;
	int num_errors = 0;
	int checks_done = 0;
	int cycles = 0;
	int nv_count = 0;
	addr_mode_ctrl u_dut (
		.clk(clk),
		.rst_n(rst_n),
		.spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si),
		.spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n),
		.nv_sr1_value(nv_sr1_value),
		.nv_sr1_write(nv_sr1_write),
		.nv_sr1_data(nv_sr1_data),
		.cap_word(cap_word),
		.bank_value(bank_value),
		.sr1_value(sr1_value),
		.cmd_valid(cmd_valid),
		.cmd_opcode(cmd_opcode),
		.cmd_addr(cmd_addr),
		.cmd_4byte(cmd_4byte)
	);
	spi_host_model u_host (
		.clk(clk),
		.spi_so(spi_so),
		.spi_so_oe_n(spi_so_oe_n),
		.spi_sck(spi_sck),
		.spi_cs_n(spi_cs_n),
		.spi_si(spi_si)
	);
	assign cmd_seen = {cmd_opcode, cmd_4byte, cmd_addr};
	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	task automatic check(input string what, input logic [40:0] seen, input logic [40:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Commands are matched in issue order; no back pressure exists
	// Sampled mid-cycle, away from the edge that launches the outputs
	always @(negedge clk)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			num_errors++;
			stop_test();
		end
		if (nv_sr1_write === 1'b1)
		begin
			nv_count++;
			// Nonvolatile copy keeps the last committed value across resets
			nv_sr1_value = nv_sr1_data;
		end
		if (cmd_valid === 1'b1)
			check("command", cmd_seen, exp_q.pop_front());
	end
	initial
	begin
		logic [7:0] d, v, w;
		logic [31:0] a;
		rst_n = 1'b0;
		void'($urandom(32'hB6DCA8CB));
		nv_sr1_value = $urandom;
		repeat (6) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		check("capability", cap_word, 32'h0000_0243);
		u_host.frame(8'h16, 0, 1, rx);
		check("bank reset", rx, 8'h00);
		u_host.frame(8'h05, 0, 1, rx);
		check("status power-up", rx, nv_sr1_value);
		d = {1'b0, 7'($urandom)};
		u_host.frame(8'h17, {16'h0000, d, ~d}, 2, rx);
		u_host.frame(8'h16, 0, 1, rx);
		check("bank write", rx, d);
		check("bank register", bank_value, d);
		$display("test bank access done");
		for (int m = 0; m < 2; m++)
		begin
			for (int i = 0; i < 4; i++)
			begin
				u_host.hp = 4 + $urandom_range(3);
				a = $urandom;
				exp_q.push_back(m ? {ops3[i], 1'b1, a} : {ops3[i], 2'b00, d[6:0], a[23:0]});
				u_host.frame(ops3[i], a, m ? 4 : 3, rx);
				exp_q.push_back({ops4[i], 1'b1, a});
				u_host.frame(ops4[i], a, 4, rx);
			end
			u_host.frame(8'hB7, 0, 0, rx);
			u_host.frame(8'h16, 0, 1, rx);
			check("wide mode", rx, {1'b1, d[6:0]});
		end
		check("commands left", exp_q.size(), 0);
		$display("test addressing done");
		v = $urandom;
		w = ~v;
		u_host.frame(8'h01, v, 1, rx);
		check("status write", sr1_value, v);
		check("nonvolatile data", nv_sr1_data, v);
		u_host.frame(8'h50, 0, 0, rx);
		u_host.frame(8'h01, w, 1, rx);
		u_host.frame(8'h05, 0, 1, rx);
		check("volatile read", rx, w);
		check("nonvolatile writes", nv_count, 1);
		$display("test status done");
		rst_n = 1'b0;
		repeat (2) @(negedge clk);
		rst_n = 1'b1;
		repeat (4) @(negedge clk);
		u_host.frame(8'h16, 0, 1, rx);
		check("bank second reset", rx, 8'h00);
		u_host.frame(8'h05, 0, 1, rx);
		check("status after reset", rx, v);
		$display("test reset done");
		stop_test();
	end
endmodule

// *** bench/spi_host_model.sv ***
`timescale 1ns/1ps
module spi_host_model
(
	input wire logic clk,
	input wire logic spi_so,
	input wire logic spi_so_oe_n,
	output logic spi_sck,
	output logic spi_cs_n,
	output logic spi_si
);
	int hp = 4;
	initial
	begin
		spi_sck = 1'b0;
		spi_cs_n = 1'b1;
		spi_si = 1'b0;
	end
	// Undriven output reads as unknown so a stale bit never matches
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
		begin
			spi_si = tx[i];
			repeat (hp) @(negedge clk);
			rx = {rx[6:0], spi_so_oe_n ? 1'bx : spi_so};
			spi_sck = 1'b1;
			repeat (hp) @(negedge clk);
			spi_sck = 1'b0;
		end
	endtask
	// One opcode, then n bytes; no write enable ever sent
	task automatic frame(input logic [7:0] op, input logic [31:0] d, input int n,
		output logic [7:0] rx);
		spi_cs_n = 1'b0;
		repeat (hp) @(negedge clk);
		xfer(op, rx);
		for (int k = n - 1; k >= 0; k--)
			xfer(d[8 * k +: 8], rx);
		repeat (hp) @(negedge clk);
		spi_cs_n = 1'b1;
		spi_si = ~spi_si;
		repeat (8) @(negedge clk);
	endtask
endmodule

// *** rtl/addr_mode_consts.svh ***
`ifndef ADDR_MODE_CONSTS_SVH
`define ADDR_MODE_CONSTS_SVH

// Opcodes
`define OP_READ_BANK 8'h16
`define OP_WRITE_BANK 8'h17
`define OP_ENTER_4B 8'hB7
`define OP_READ_SR1 8'h05
`define OP_WRITE_SR1 8'h01
`define OP_VOL_SR_EN 8'h50
`define OP_READ_3B 8'h03
`define OP_FAST_READ_3B 8'h0B
`define OP_PROGRAM_3B 8'h02
`define OP_ERASE_3B 8'h20
`define OP_READ_4B 8'h13
`define OP_FAST_READ_4B 8'h0C
`define OP_PROGRAM_4B 8'h12
`define OP_ERASE_4B 8'h21

// Bank register layout; bank and status register reset values
`define BANK_MODE_BIT 7
`define BANK_RESET 8'h00
`define SR1_RESET 8'h00

// 4-byte capability word: 1 = supported, 0 = not
`define CAP_READ_BIT 0
`define CAP_FAST_READ_BIT 1
`define CAP_PROGRAM_BIT 6
`define CAP_ERASE_BIT 9
`define CAP_WORD 32'h0000_0243

// Bit counts
`define BITS_PER_BYTE 6'h08
`define ADDR3_BITS 6'h18
`define ADDR4_BITS 6'h20
`define LAST_BIT 3'h7

`endif

// *** rtl/addr_mode_ctrl.sv ***
`timescale 1ns/1ps
`include "addr_mode_consts.svh"

module addr_mode_ctrl
	import addr_mode_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire logic spi_sck,
	input wire logic spi_cs_n,
	input wire logic spi_si,
	output logic spi_so,
	output logic spi_so_oe_n,
	input wire logic [7:0] nv_sr1_value,
	output logic nv_sr1_write,
	output logic [7:0] nv_sr1_data,
	output logic [31:0] cap_word,
	output logic [7:0] bank_value,
	output logic [7:0] sr1_value,
	output logic cmd_valid,
	output logic [7:0] cmd_opcode,
	output logic [31:0] cmd_addr,
	output logic cmd_4byte
);

	state_type state_reg;
	state_type state_next;

	// A literal cannot be bit-selected, so the capability word gets a name
	localparam logic [31:0] CAP_BITS = `CAP_WORD;

	// A 4-byte opcode is accepted only if its capability bit is set
	function automatic logic is_4b_op(input logic [7:0] op);
		logic hit;
		hit = 1'b0;
		case (op)
			`OP_READ_4B: hit = CAP_BITS[`CAP_READ_BIT];
			`OP_FAST_READ_4B: hit = CAP_BITS[`CAP_FAST_READ_BIT];
			`OP_PROGRAM_4B: hit = CAP_BITS[`CAP_PROGRAM_BIT];
			`OP_ERASE_4B: hit = CAP_BITS[`CAP_ERASE_BIT];
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	function automatic logic is_3b_op(input logic [7:0] op);
		return (op == `OP_READ_3B) || (op == `OP_FAST_READ_3B) ||
			(op == `OP_PROGRAM_3B) || (op == `OP_ERASE_3B);
	endfunction

	always_comb
	begin
		logic rise;
		logic fall;
		logic sel;
		logic [7:0] byte_in;
		rise = 1'b0;
		fall = 1'b0;
		sel = 1'b0;
		byte_in = 8'h00;
		state_next = state_reg;
		state_next.sck_sync = {state_reg.sck_sync[0], spi_sck};
		state_next.cs_n_sync = {state_reg.cs_n_sync[0], spi_cs_n};
		state_next.si_sync = {state_reg.si_sync[0], spi_si};
		state_next.sck_prev = state_reg.sck_sync[1];
		state_next.nv_write = 1'b0;
		state_next.cmd_valid = 1'b0;
		rise = state_reg.sck_sync[1] && !state_reg.sck_prev;
		fall = !state_reg.sck_sync[1] && state_reg.sck_prev;
		sel = !state_reg.cs_n_sync[1];
		byte_in = {state_reg.shift_in[6:0], state_reg.si_sync[1]};

		// Power-up load waits one clock after reset so no port feeds reset
		if (!state_reg.sr1_loaded)
		begin
			state_next.sr1 = nv_sr1_value;
			state_next.sr1_loaded = 1'b1;
		end

		if (!sel)
		begin
			state_next.phase = ST_IDLE;
			state_next.bit_cnt = 6'h00;
		end
		else
		begin
			case (state_reg.phase)
				ST_IDLE:
				begin
					state_next.phase = ST_OPCODE;
					state_next.bit_cnt = 6'h00;
				end
				ST_OPCODE:
				begin
					if (rise)
					begin
						state_next.shift_in = {state_reg.shift_in[30:0], state_reg.si_sync[1]};
						state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
						if (state_reg.bit_cnt[2:0] == `LAST_BIT)
						begin
							state_next.opcode = byte_in;
							state_next.bit_cnt = 6'h00;
							state_next.phase = ST_DONE;
							state_next.out_first = 1'b1;
							case (byte_in)
								`OP_READ_BANK:
								begin
									state_next.shift_out = state_reg.bank;
									state_next.phase = ST_DATA_OUT;
								end
								`OP_READ_SR1:
								begin
									// Reads follow whichever copy is live
									state_next.shift_out = state_reg.sr1;
									state_next.phase = ST_DATA_OUT;
								end
								`OP_WRITE_BANK:
								begin
									state_next.target = TGT_BANK;
									state_next.phase = ST_DATA_IN;
								end
								`OP_WRITE_SR1:
								begin
									state_next.target = TGT_SR1;
									state_next.phase = ST_DATA_IN;
								end
								`OP_ENTER_4B:
									state_next.bank[`BANK_MODE_BIT] = 1'b1;
								`OP_VOL_SR_EN:
									state_next.vol_active = 1'b1;
								default:
								begin
									if (is_4b_op(byte_in))
									begin
										state_next.addr_bits = `ADDR4_BITS;
										state_next.phase = ST_ADDR;
									end
									else if (is_3b_op(byte_in))
									begin
										state_next.addr_bits = state_reg.bank[`BANK_MODE_BIT] ?
											`ADDR4_BITS : `ADDR3_BITS;
										state_next.phase = ST_ADDR;
									end
								end
							endcase
						end
					end
				end
				ST_ADDR:
				begin
					if (rise)
					begin
						state_next.shift_in = {state_reg.shift_in[30:0], state_reg.si_sync[1]};
						state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
						if (state_reg.bit_cnt + 6'h01 == state_reg.addr_bits)
						begin
							state_next.cmd_valid = 1'b1;
							state_next.cmd_opcode = state_reg.opcode;
							state_next.cmd_4byte = (state_reg.addr_bits == `ADDR4_BITS);
							if (state_reg.addr_bits == `ADDR4_BITS)
								state_next.cmd_addr = {state_reg.shift_in[30:0],
									state_reg.si_sync[1]};
							else
								state_next.cmd_addr = {1'b0, state_reg.bank[6:0],
									state_reg.shift_in[22:0], state_reg.si_sync[1]};
							state_next.phase = ST_DONE;
						end
					end
				end
				ST_DATA_IN:
				begin
					if (rise)
					begin
						state_next.shift_in = {state_reg.shift_in[30:0], state_reg.si_sync[1]};
						state_next.bit_cnt = state_reg.bit_cnt + 6'h01;
						if (state_reg.bit_cnt[2:0] == `LAST_BIT)
						begin
							// Only the first byte counts; extra bytes are ignored
							state_next.phase = ST_DONE;
							if (state_reg.target == TGT_BANK)
								state_next.bank = byte_in;
							else
							begin
								state_next.sr1 = byte_in;
								if (!state_reg.vol_active)
								begin
									state_next.nv_write = 1'b1;
									state_next.nv_data = byte_in;
								end
							end
						end
					end
				end
				ST_DATA_OUT:
				begin
					if (fall)
					begin
						// First falling edge keeps the MSB already driven
						if (state_reg.out_first)
							state_next.out_first = 1'b0;
						else
							state_next.shift_out = {state_reg.shift_out[6:0],
								state_reg.shift_out[7]};
					end
				end
				ST_DONE:
					state_next.phase = ST_DONE;
				default:
					state_next.phase = ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
			state_reg.sck_sync <= 2'h0;
			state_reg.cs_n_sync <= 2'h3;
			state_reg.phase <= ST_IDLE;
			state_reg.bank <= `BANK_RESET;
			state_reg.sr1 <= `SR1_RESET;
		end
		else
			state_reg <= state_next;
	end

	assign spi_so = state_reg.shift_out[7];
	assign spi_so_oe_n = !(state_reg.phase == ST_DATA_OUT);
	assign nv_sr1_write = state_reg.nv_write;
	assign nv_sr1_data = state_reg.nv_data;
	assign cap_word = `CAP_WORD;
	assign bank_value = state_reg.bank;
	assign sr1_value = state_reg.sr1;
	assign cmd_valid = state_reg.cmd_valid;
	assign cmd_opcode = state_reg.cmd_opcode;
	assign cmd_addr = state_reg.cmd_addr;
	assign cmd_4byte = state_reg.cmd_4byte;

endmodule

// *** rtl/addr_mode_pkg.sv ***
package addr_mode_pkg;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_OPCODE = 3'b001,
		ST_ADDR = 3'b010,
		ST_DATA_IN = 3'b011,
		ST_DATA_OUT = 3'b100,
		ST_DONE = 3'b101
	} phase_type;

	typedef enum logic [0:0] {
		TGT_BANK = 1'b0,
		TGT_SR1 = 1'b1
	} target_type;

	typedef struct packed {
		logic [1:0] sck_sync;
		logic [1:0] cs_n_sync;
		logic [1:0] si_sync;
		logic sck_prev;
		phase_type phase;
		target_type target;
		logic [5:0] bit_cnt;
		logic [5:0] addr_bits;
		logic [7:0] opcode;
		logic [31:0] shift_in;
		logic [7:0] shift_out;
		logic out_first;
		logic [7:0] bank;
		logic [7:0] sr1;
		logic vol_active;
		logic sr1_loaded;
		logic nv_write;
		logic [7:0] nv_data;
		logic cmd_valid;
		logic [7:0] cmd_opcode;
		logic [31:0] cmd_addr;
		logic cmd_4byte;
	} state_type;

endpackage
